// [sim/dac_gain_offset_calibration_bench.sv]
module dac_gain_offset_calibration_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import dgoc_pkg::*;
	`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
		$display("mismatch at %0t got %h expected %h", $time, (a), (e)); end end
	logic          clk = 1'b0;
	logic          reset = 1'b1;
	logic [7:0]    addr;
	logic [15:0]   wdata, rdata, q, e, v;
	logic          wr, rd, busy, en;
	logic [255:0]  dac_words;
	logic [15:0]   g[32], o[32];
	logic [4:0]    sel[16];
	int            miscompares = 0, checked = 0, cycles = 0, seed = 88546, d;

	always #12.5 clk = ~clk;

	dgoc_top dgoc_top_i (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .dac_words(dac_words), .busy(busy));
	dgoc_host dgoc_host_i (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

	function automatic logic [15:0] expw(input logic [15:0] x, input logic [15:0] m, input logic [15:0] c);
		longint r;
		if (!en) return x;
		r = ((longint'(x) * (longint'(m) + 1)) >>> 16) + longint'(c) - 32768;
		return (r < 0) ? 16'h0000 : (r > 65535) ? 16'hffff : r[15:0];
	endfunction

	task automatic test_done();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic check_dac(input int k, input logic [15:0] x);
		e = expw(x, g[sel[k]], o[sel[k]]);
		`CHK(dac_words[k*16+:16], e)
		dgoc_host_i.get(DGOC_DATA_BASE + 8'(k), q);
		`CHK(q, e)
	endtask

	task automatic data(input int k, input logic [15:0] x);
		dgoc_host_i.put(DGOC_DATA_BASE + 8'(k), x);
		#1 `CHK(busy, 1'b1)
		repeat (3) @(posedge clk);
		#1 `CHK(busy, 1'b0)
		check_dac(k, x);
	endtask

	task automatic trim(input logic [4:0] s, input logic [15:0] m, input logic [15:0] c);
		g[s] = m;
		o[s] = c;
		dgoc_host_i.put(DGOC_GAIN_BASE + 8'(s), m);
		dgoc_host_i.put(DGOC_OFS_BASE + 8'(s), c);
	endtask

	task automatic restart(input int n);
		reset <= 1'b1;
		repeat (n) @(posedge clk);
		reset <= 1'b0;
		for (int i = 0; i < 32; i++) begin
			g[i] = DGOC_GAIN_RST;
			o[i] = DGOC_OFS_RST;
		end
		for (int i = 0; i < 16; i++)
			sel[i] = 5'(i);
		en = 1'b1;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles > 20000) begin
			miscompares++;
			test_done();
		end
	end

	initial begin
		restart(10);
		`CHK(dac_words[79:64], 16'h0000)
		dgoc_host_i.get(DGOC_GAIN_BASE + 8'd5, q);
		`CHK(q, DGOC_GAIN_RST)
		dgoc_host_i.get(DGOC_OFS_BASE + 8'd5, q);
		`CHK(q, DGOC_OFS_RST)
		data(5, 16'h1234);
		// clamp and truncation corners on one slot
		trim(2, 16'hffff, 16'hffff); data(2, 16'hffff);
		trim(2, 16'h0000, 16'h0000); data(2, 16'h0010);
		trim(2, 16'h7fff, 16'h8000); data(2, 16'hc000);
		trim(2, 16'hffff, 16'h8100); data(2, 16'h4000);
		trim(2, 16'h1234, 16'h9000); data(2, 16'h0000);
		repeat (40) begin
			d = $unsigned($random(seed)) % 16;
			sel[d] = 5'($unsigned($random(seed)) % 32);
			dgoc_host_i.put(DGOC_SEL_BASE + 8'(d), 16'(sel[d]));
			trim(sel[d], 16'($random(seed)), 16'($random(seed)));
			data(d, 16'($random(seed)));
		end
		// trim write alone must not move the word, rewrite of same data must
		v = 16'h9abc;
		data(3, v);
		e = expw(v, g[sel[3]], o[sel[3]]);
		trim(sel[3], 16'h8000, 16'h7000);
		dgoc_host_i.put(8'h7e, 16'h5555);
		repeat (3) @(posedge clk);
		`CHK(dac_words[63:48], e)
		dgoc_host_i.get(8'h7e, q);
		`CHK(q, 16'h0000)
		data(3, v);
		sel[3] = 5'd20;
		dgoc_host_i.put(DGOC_SEL_BASE + 8'd3, 16'd20);
		data(3, v);
		// dual write, each channel with its own trims
		trim(sel[0], 16'hc000, 16'h8200);
		trim(sel[1], 16'h4000, 16'h7e00);
		dgoc_host_i.put(DGOC_BOTH_ADDR, 16'h8888);
		repeat (4) @(posedge clk);
		#1 check_dac(0, 16'h8888);
		check_dac(1, 16'h8888);
		// chip-wide bypass
		dgoc_host_i.put(DGOC_CTL_ADDR, 16'h0000);
		en = 1'b0;
		dgoc_host_i.get(DGOC_CTL_ADDR, q);
		`CHK(q, 16'h0000)
		data(7, 16'h2468);
		data(12, 16'hfedc);
		dgoc_host_i.put(DGOC_BOTH_ADDR, 16'h1357);
		repeat (4) @(posedge clk);
		#1 check_dac(0, 16'h1357);
		check_dac(1, 16'h1357);
		dgoc_host_i.put(DGOC_CTL_ADDR, 16'h0001);
		en = 1'b1;
		data(7, 16'h2468);
		// two-point calibration of dac 4, offset trim worked out from it
		trim(sel[4], DGOC_GAIN_RST, DGOC_OFS_RST);
		data(4, 16'h4000);
		data(4, 16'hc000);
		trim(sel[4], 16'hcccb, DGOC_MID + 16'h0148);
		data(4, 16'h4000);
		// reset in mid-run drops every trim, the host loads slot 9 again
		restart(2);
		`CHK(dac_words, 256'h0)
		dgoc_host_i.get(DGOC_GAIN_BASE + 8'd9, q);
		`CHK(q, DGOC_GAIN_RST)
		dgoc_host_i.get(DGOC_OFS_BASE + 8'd9, q);
		`CHK(q, DGOC_OFS_RST)
		dgoc_host_i.get(DGOC_CTL_ADDR, q);
		`CHK(q, 16'h0001)
		trim(5'd9, 16'hf000, 16'h8400);
		data(9, 16'h5000);
		test_done();
	end
endmodule

// [sim/dgoc_host.sv]
module dgoc_host (
	// clock
	input  wire logic        clk,
	// register port
	output logic      [7:0]  addr,
	output logic      [15:0] wdata,
	output logic             wr,
	output logic             rd,
	input  wire logic [15:0] rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		addr = 8'h00;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
	end
	// host reloads slot 9 trims after reset and sends data in the reset mode, see bench sequence
	task automatic put(input logic [7:0] a, input logic [15:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		// released bus carries the inverse so no stale word looks valid
		addr <= ~a;
		wdata <= ~v;
	endtask
	task automatic get(input logic [7:0] a, output logic [15:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
endmodule

// [verilog/dgoc_calc_if.sv]
interface dgoc_calc_if;
	logic [15:0] in_word;
	logic [15:0] gain;
	logic [15:0] offset;
	logic        enable;
	logic [15:0] result;
	modport engine (input in_word, input gain, input offset, input enable, output result);
	modport user   (output in_word, output gain, output offset, output enable, input result);
endinterface

// [verilog/dgoc_engine.sv]
module dgoc_engine (
	dgoc_calc_if.engine c
);
	import dgoc_pkg::*;
	logic [32:0] prod;
	logic signed [19:0] sum;
	// fraction dropped; offset added unscaled, result clamped
	always_comb begin
		prod = {1'b0, c.in_word} * ({1'b0, c.gain} + 17'h00001);
		sum  = $signed({4'h0, prod[31:16]}) + $signed({4'h0, c.offset}) - $signed({4'h0, DGOC_MID});
		if (!c.enable) begin
			c.result = c.in_word;
		end else if (sum < $signed(20'h00000)) begin
			c.result = 16'h0000;
		end else if (sum > $signed(20'h0ffff)) begin
			c.result = 16'hffff;
		end else begin
			c.result = sum[15:0];
		end
	end
endmodule

// [verilog/dgoc_pkg.sv]
package dgoc_pkg;
	// ----------------------------------------
	// widths and reset values
	// ----------------------------------------
	localparam int          DGOC_W        = 16;
	localparam logic [15:0] DGOC_GAIN_RST = 16'hffff;
	localparam logic [15:0] DGOC_OFS_RST  = 16'h8000;
	localparam logic [15:0] DGOC_MID      = 16'h8000;
	localparam logic        DGOC_CTL_RST  = 1'b1;
	localparam int          DGOC_CTL_EN   = 0;
	localparam int          DGOC_AW       = 8;

	// ----------------------------------------
	// register map: 0x00..0x0f input words, 0x10 dual write to dacs 0 and 1, 0x11 control,
	// 0x20..0x3f gain per trim slot, 0x40..0x5f offset per trim slot,
	// 0x60..0x6f slot select per dac
	// ----------------------------------------
	localparam logic [7:0] DGOC_DATA_BASE = 8'h00;
	localparam logic [7:0] DGOC_CTL_ADDR  = 8'h11;
	localparam logic [7:0] DGOC_BOTH_ADDR = 8'h10;
	localparam logic [7:0] DGOC_GAIN_BASE = 8'h20;
	localparam logic [7:0] DGOC_OFS_BASE  = 8'h40;
	localparam logic [7:0] DGOC_SEL_BASE  = 8'h60;
	localparam logic [7:0] DGOC_ID_ADDR   = 8'h7f;
	// arbitrary value, block identity
	localparam logic [15:0] DGOC_ID       = 16'h5a01;

	typedef enum logic [1:0] {
		DGOC_IDLE = 2'b00,
		DGOC_CALC = 2'b01,
		DGOC_SECOND = 2'b11
	} dgoc_state_t;
endpackage

// [verilog/dgoc_top.sv]
// Operation
// - each dac takes its gain and offset trim from the slot its select register names
// - shared dacs get a trim pair per level or range slot
// - gain trims reset to all ones
// - offset trims reset to midscale
// - control bit 0 clear means no correction
// - bypass acts on all dacs at once
// - adjusted equals input times gain+1 over 2^16 plus offset minus midscale
// - adjusted word drives dac and is what reads return
// - offset added in raw lsb, not scaled by gain
// - adjusted word recomputed only on an input word write
// - trim writes leave adjusted words untouched
// - dual-channel write updates both words one after another
// - one adjusted word per dac, no per-range copies
// - data write uses the trim slot currently selected
module dgoc_top #(
	parameter int NDAC  = 16,
	parameter int NSLOT = 32
) (
	// clock and reset
	input  wire logic                         clk,
	input  wire logic                         reset,
	// register port
	input  wire logic [dgoc_pkg::DGOC_AW-1:0] addr,
	input  wire logic [15:0]                  wdata,
	input  wire logic                         wr,
	input  wire logic                         rd,
	output logic      [15:0]                  rdata,
	// dac words
	output logic      [NDAC*16-1:0]           dac_words,
	output logic                              busy
);
	import dgoc_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [15:0] gain  [NSLOT];
	logic [15:0] ofs   [NSLOT];
	logic [4:0]  sel   [NDAC];
	logic [15:0] adj   [NDAC];
	logic        cal_en;
	logic [15:0] pend;
	logic [3:0]  tgt;
	dgoc_state_t state;

	logic [15:0] next_gain [NSLOT];
	logic [15:0] next_ofs  [NSLOT];
	logic [4:0]  next_sel  [NDAC];
	logic [15:0] next_adj  [NDAC];
	logic        next_cal_en;
	logic [15:0] next_pend;
	logic [3:0]  next_tgt;
	dgoc_state_t next_state;
	logic [15:0] next_rdata;
	logic        next_busy;
	logic        trims_at_rst;

	dgoc_calc_if c ();
	dgoc_engine u_engine (.c(c));

	function automatic logic in_range(input logic [7:0] a, input logic [7:0] base, input int n);
		in_range = (a >= base) && (32'(a) < 32'(base) + n);
	endfunction

	// ----------------------------------------
	// reference arithmetic for the checks
	// ----------------------------------------
	// worked in wide signed arithmetic, apart from the engine's narrow datapath
	function automatic logic [15:0] ref_word(input logic [15:0] x, input logic [15:0] m, input logic [15:0] k);
		longint r;
		r = ((longint'(x) * (longint'(m) + 64'sh1)) / 64'sh10000) + longint'(k) - longint'(DGOC_MID);
		if (r < 64'sh0) begin
			ref_word = 16'h0000;
		end else if (r > 64'shffff) begin
			ref_word = 16'hffff;
		end else begin
			ref_word = r[15:0];
		end
	endfunction

	// ----------------------------------------
	// engine hookup
	// ----------------------------------------
	always_comb begin
		c.in_word = pend;
		c.gain    = gain[sel[tgt]];
		c.offset  = ofs[sel[tgt]];
		c.enable  = cal_en;
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_gain   = gain;
		next_ofs    = ofs;
		next_sel    = sel;
		next_adj    = adj;
		next_cal_en = cal_en;
		next_pend   = pend;
		next_tgt    = tgt;
		next_state  = state;
		next_rdata  = 16'h0000;
		// trim writes never touch adj
		unique case (state)
			DGOC_IDLE: begin
				if (wr) begin
					if (in_range(addr, DGOC_DATA_BASE, NDAC)) begin
						next_pend  = wdata;
						next_tgt   = addr[3:0];
						next_state = DGOC_CALC;
					end else if (addr == DGOC_BOTH_ADDR) begin
						next_pend  = wdata;
						next_tgt   = 4'h0;
						next_state = DGOC_SECOND;
					end else if (addr == DGOC_CTL_ADDR) begin
						next_cal_en = wdata[DGOC_CTL_EN];
					end else if (in_range(addr, DGOC_GAIN_BASE, NSLOT)) begin
						next_gain[addr[4:0]] = wdata;
					end else if (in_range(addr, DGOC_OFS_BASE, NSLOT)) begin
						next_ofs[addr[4:0]] = wdata;
					end else if (in_range(addr, DGOC_SEL_BASE, NDAC)) begin
						next_sel[addr[3:0]] = wdata[4:0];
					end
				end
			end
			DGOC_SECOND: begin
				next_adj[tgt] = c.result;
				next_tgt      = 4'h1;
				next_state    = DGOC_CALC;
			end
			DGOC_CALC: begin
				next_adj[tgt] = c.result;
				next_state    = DGOC_IDLE;
			end
			default: next_state = DGOC_IDLE;
		endcase
		// busy comes from the next state so the pin is a clean flop, aligned with the word update
		next_busy = (next_state != DGOC_IDLE);
		if (rd) begin
			if (in_range(addr, DGOC_DATA_BASE, NDAC)) begin
				next_rdata = adj[addr[3:0]];
			end else if (addr == DGOC_CTL_ADDR) begin
				next_rdata = {15'h0000, cal_en};
			end else if (in_range(addr, DGOC_GAIN_BASE, NSLOT)) begin
				next_rdata = gain[addr[4:0]];
			end else if (in_range(addr, DGOC_OFS_BASE, NSLOT)) begin
				next_rdata = ofs[addr[4:0]];
			end else if (in_range(addr, DGOC_SEL_BASE, NDAC)) begin
				next_rdata = {11'h000, sel[addr[3:0]]};
			end else if (addr == DGOC_ID_ADDR) begin
				next_rdata = DGOC_ID;
			end
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < NSLOT; i++) begin
				gain[i] <= DGOC_GAIN_RST;
				ofs[i]  <= DGOC_OFS_RST;
			end
			for (int i = 0; i < NDAC; i++) begin
				sel[i] <= 5'(i);
				adj[i] <= 16'h0000;
			end
			cal_en <= DGOC_CTL_RST;
			pend   <= 16'h0000;
			tgt    <= 4'h0;
			state  <= DGOC_IDLE;
			rdata  <= 16'h0000;
			busy   <= 1'b0;
		end else begin
			gain   <= next_gain;
			ofs    <= next_ofs;
			sel    <= next_sel;
			adj    <= next_adj;
			cal_en <= next_cal_en;
			pend   <= next_pend;
			tgt    <= next_tgt;
			state  <= next_state;
			rdata  <= next_rdata;
			busy   <= next_busy;
		end
	end

	// dac words straight from flops
	always_comb begin
		for (int i = 0; i < NDAC; i++) begin
			dac_words[i*16 +: 16] = adj[i];
		end
	end

	// all trim slots at their reset codes, watched right after reset
	always_comb begin
		trims_at_rst = 1'b1;
		for (int i = 0; i < NSLOT; i++) begin
			trims_at_rst = trims_at_rst && (gain[i] == DGOC_GAIN_RST) && (ofs[i] == DGOC_OFS_RST);
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_data_wr;
		wr && state == DGOC_IDLE && addr < 8'(NDAC);
	endsequence

	chk_data_recompute: assert property (@(posedge clk) disable iff (reset)
		s_data_wr |=> state == DGOC_CALC ##1 state == DGOC_IDLE)
		else $error("data write did not recompute");

	chk_trim_hold: assert property (@(posedge clk) disable iff (reset)
		state == DGOC_IDLE && !(wr && (addr < 8'(NDAC) || addr == DGOC_BOTH_ADDR)) |=> $stable(dac_words))
		else $error("adjusted word changed without data write");

	chk_bypass_pass: assert property (@(posedge clk) disable iff (reset)
		state == DGOC_CALC && !cal_en |=> adj[$past(tgt)] == $past(pend))
		else $error("bypass altered data");

	chk_dual_order: assert property (@(posedge clk) disable iff (reset)
		wr && state == DGOC_IDLE && addr == DGOC_BOTH_ADDR |=> state == DGOC_SECOND ##1 (state == DGOC_CALC && tgt == 4'h1))
		else $error("dual write sequence wrong");

	chk_read_adj: assert property (@(posedge clk) disable iff (reset)
		rd && addr < 8'(NDAC) |=> rdata == $past(adj[addr[3:0]]))
		else $error("read did not return adjusted word");

	chk_unity_mid: assert property (@(posedge clk) disable iff (reset)
		state == DGOC_CALC && cal_en && c.gain == 16'hffff && c.offset == DGOC_MID |-> c.result == pend)
		else $error("unity trims changed data");

	chk_offset_raw: assert property (@(posedge clk) disable iff (reset)
		cal_en && pend == 16'h0000 && c.offset >= DGOC_MID |-> c.result == c.offset - DGOC_MID)
		else $error("offset was scaled");

	chk_clamp_top: assert property (@(posedge clk) disable iff (reset)
		cal_en && c.gain == 16'hffff && pend == 16'hffff && c.offset == 16'hffff |-> c.result == 16'hffff)
		else $error("result not clamped");

	// dual write walks dac 0, then dac 1, then returns to idle
	sequence s_dual_wr;
		wr && state == DGOC_IDLE && addr == DGOC_BOTH_ADDR;
	endsequence

	sequence s_dual_run;
		state == DGOC_SECOND && tgt == 4'h0 ##1 state == DGOC_CALC && tgt == 4'h1 ##1 state == DGOC_IDLE;
	endsequence

	chk_dual_walk: assert property (@(posedge clk) disable iff (reset)
		s_dual_wr |=> s_dual_run)
		else $error("dual write did not walk both channels");

	chk_dual_first: assert property (@(posedge clk) disable iff (reset)
		state == DGOC_SECOND |=> dac_words[15:0] == $past(c.result))
		else $error("dac 0 word not taken on dual write");

	chk_dual_second: assert property (@(posedge clk) disable iff (reset)
		state == DGOC_CALC && tgt == 4'h1 |=> dac_words[31:16] == $past(c.result))
		else $error("dac 1 word not taken on dual write");

	chk_formula_all: assert property (@(posedge clk) disable iff (reset)
		(state == DGOC_SECOND || state == DGOC_CALC) && cal_en |-> c.result == ref_word(pend, c.gain, c.offset))
		else $error("adjusted word off the correction formula");

	chk_bypass_all: assert property (@(posedge clk) disable iff (reset)
		(state == DGOC_SECOND || state == DGOC_CALC) && !cal_en |-> c.result == pend)
		else $error("bypass not applied to every dac");

	// a dual write must see one enable for both channels
	chk_cal_hold: assert property (@(posedge clk) disable iff (reset)
		state != DGOC_IDLE |=> $stable(cal_en))
		else $error("enable moved during a computation");

	chk_busy_pulse: assert property (@(posedge clk) disable iff (reset)
		s_data_wr |=> busy ##1 !busy)
		else $error("busy did not frame the computation");

	chk_trim_reset: assert property (@(posedge clk)
		reset |=> trims_at_rst)
		else $error("trims not at reset values");

	chk_word_reset: assert property (@(posedge clk)
		reset |=> dac_words == '0 && !busy && rdata == 16'h0000)
		else $error("outputs not cleared by reset");

	chk_read_idle: assert property (@(posedge clk) disable iff (reset)
		!rd |=> rdata == 16'h0000)
		else $error("read data outside a read cycle");

	chk_ctl_read: assert property (@(posedge clk) disable iff (reset)
		rd && addr == DGOC_CTL_ADDR |=> rdata == {15'h0000, $past(cal_en)})
		else $error("control read wrong");
endmodule
